// file: shared/ddc_cfg.svh
`ifndef DDC_CFG_SVH
`define DDC_CFG_SVH
// ****************************************************************
// sizes and positions
// ****************************************************************
`define DDC_IN_W        16
`define DDC_ACC_W       20
`define DDC_NCO_W       32
`define DDC_LUT_BITS    8
`define DDC_OUT_W_MAX   20
`define DDC_OUT_W_MIN   14
`define DDC_FIFO_DEPTH  16
// ****************************************************************
// reset values and codes
// ****************************************************************
`define DDC_RST_DEC_LOG 3'h1
`define DDC_RST_RES     5'h10
`define DDC_MAX_DEC_LOG 3'h5
// 3 dB gain is x1.4142 = x + x/4 + x/8 + x/32 + x/64 (approx)
`define DDC_SQRT2_SH1   2
`define DDC_SQRT2_SH2   3
`define DDC_SQRT2_SH3   5
`define DDC_SQRT2_SH4   6
`endif

// file: shared/ddc_pkg.sv
package ddc_pkg;
    // ****************************************************************
    // mode types
    // ****************************************************************
    typedef enum logic [1:0] {
        DDC_MODE_COMPLEX,
        DDC_MODE_REAL,
        DDC_MODE_QUARTER
    } ddc_mode_t;

    typedef enum logic {
        DDC_REF_PIN,
        DDC_REF_SOFT
    } ddc_refsel_t;

    typedef logic signed [19:0] ddc_word_t;
endpackage : ddc_pkg

// file: shared/ddc_link_if.sv
`timescale 1ns/1ps
// ****************************************************************
// stream of decimated words (raw samples in bypass) from converter end to host end
// ****************************************************************
interface ddc_link_if;
    logic        valid;
    logic        ready;
    logic [19:0] data;
    logic        is_q;

    modport dev  (output valid, output data, output is_q, input ready);
    modport host (input valid, input data, input is_q, output ready);
endinterface : ddc_link_if

// file: rtl/ddc_fifo.sv
`timescale 1ns/1ps
// ****************************************************************
// flip-flop fifo with valid and ready on both sides
// ****************************************************************
module ddc_fifo #(
    parameter int WIDTH = 21,
    parameter int DEPTH = 16
) (
    input  wire logic             mclk,
    input  wire logic             rst,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [AW-1:0]    wptr_reg;
    logic [AW-1:0]    rptr_reg;
    logic [AW:0]      count_reg;
    logic             push;
    logic             pop;

    // honest full and empty
    assign in_ready  = (count_reg != (AW+1)'(DEPTH));
    assign out_valid = (count_reg != '0);
    assign out_data  = mem_reg[rptr_reg];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    // storage
    always_ff @(posedge mclk) begin
        if (push) begin
            mem_reg[wptr_reg] <= in_data;
        end
    end

    // pointers and count
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            wptr_reg  <= '0;
            rptr_reg  <= '0;
            count_reg <= '0;
        end else begin
            if (push) begin
                wptr_reg <= wptr_reg + AW'(1);
            end
            if (pop) begin
                rptr_reg <= rptr_reg + AW'(1);
            end
            count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule : ddc_fifo

// file: rtl/ddc_dev.sv
`timescale 1ns/1ps
`include "ddc_cfg.svh"
module ddc_dev
    import ddc_pkg::*;
#(
    parameter int DEC_LOG_MAX = 5
) (
    input  wire logic                  mclk,
    input  wire logic                  rst,
    input  wire logic signed [15:0]    conv_ch_one,
    input  wire logic signed [15:0]    conv_ch_two,
    input  wire logic                  ddc_enable,
    input  wire ddc_pkg::ddc_mode_t    mode,
    input  wire logic [2:0]            dec_log,
    input  wire logic                  path_swap,
    input  wire logic                  gain_en,
    input  wire logic                  phase_invert,
    input  wire logic [31:0]           nco_word,
    input  wire logic                  mixer_restart,
    input  wire logic                  sync_pin,
    input  wire logic [4:0]            out_res,
    input  wire logic                  use_path_two,
    input  wire logic                  reference_select_pin,
    input  wire ddc_pkg::ddc_refsel_t  ref_source,
    input  wire logic                  ref_soft_mode,
    output logic                       ref_mode,
    ddc_link_if.dev                    link
);
    import ddc_pkg::*;

    // ****************************************************************
    // pin synchronisers
    // ****************************************************************
    logic sync_s1_reg, sync_s2_reg, sync_s3_reg;
    logic refp_s1_reg, refp_s2_reg;
    logic restart_d_reg;
    logic restart_evt;

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            sync_s1_reg   <= 1'b0;
            sync_s2_reg   <= 1'b0;
            sync_s3_reg   <= 1'b0;
            refp_s1_reg   <= 1'b1;
            refp_s2_reg   <= 1'b1;
            restart_d_reg <= 1'b0;
        end else begin
            sync_s1_reg   <= sync_pin;
            sync_s2_reg   <= sync_s1_reg;
            sync_s3_reg   <= sync_s2_reg;
            refp_s1_reg   <= reference_select_pin;
            refp_s2_reg   <= refp_s1_reg;
            restart_d_reg <= mixer_restart;
        end
    end

    // toggle of restart bit or sync pin loads the word
    assign restart_evt = (restart_d_reg != mixer_restart) || (sync_s2_reg != sync_s3_reg);

    // reference mode follows the pin unless software owns it
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            ref_mode <= 1'b1;
        end else begin
            ref_mode <= (ref_source == DDC_REF_PIN) ? refp_s2_reg : ref_soft_mode;
        end
    end

    // ****************************************************************
    // crossbar and oscillator
    // ****************************************************************
    logic signed [15:0] sel_sample;
    logic [31:0]        freq_reg;
    logic [31:0]        phase_reg;
    logic [7:0]         ph_idx;
    logic signed [15:0] cos_v, sin_v;

    // either path may take either converter channel
    assign sel_sample = (use_path_two ^ path_swap) ? conv_ch_two : conv_ch_one;

    // signed word adds to phase; pending word loaded on restart
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            freq_reg  <= '0;
            phase_reg <= '0;
        end else if (restart_evt) begin
            freq_reg  <= nco_word;
            phase_reg <= '0;
        end else begin
            phase_reg <= phase_reg + freq_reg;
        end
    end

    assign ph_idx = phase_reg[31:24];

    // coarse sine by quadrant-folded triangle approximation
    function automatic logic signed [15:0] tri_wave(input logic [7:0] p);
        logic [5:0]  f;
        logic [15:0] mag;
        f   = p[6] ? ~p[5:0] : p[5:0];
        mag = {1'b0, f[5:0], 9'h000};
        return p[7] ? -$signed(mag) : $signed(mag);
    endfunction : tri_wave

    assign sin_v = tri_wave(ph_idx);
    assign cos_v = tri_wave(ph_idx + 8'h40);

    // ****************************************************************
    // mixer (complex and quarter modes): e^{+jwn} by default, e^{-jwn} when inverted
    // ****************************************************************
    logic signed [31:0] mi_full, mq_full;
    logic signed [19:0] mix_i, mix_q;

    assign mi_full = sel_sample * cos_v;
    assign mq_full = sel_sample * sin_v;
    always_comb begin
        if (mode == DDC_MODE_REAL) begin
            mix_i = {sel_sample, 4'h0};
            mix_q = '0;
        end else begin
            mix_i = mi_full[30:11];
            mix_q = phase_invert ? -mq_full[30:11] : mq_full[30:11];
        end
    end

    // ****************************************************************
    // decimator: boxcar accumulate at 26 bits, dump at 20 bits
    // ****************************************************************
    logic [4:0]         dec_cnt_reg;
    logic [4:0]         dec_last;
    logic [2:0]         dec_sel;
    logic signed [25:0] acc_i_reg, acc_q_reg;
    logic signed [19:0] avg_i, avg_q;
    logic               dump;

    assign dec_sel  = (dec_log == 3'h0) ? 3'h1 : (dec_log > 3'(DEC_LOG_MAX)) ? 3'(DEC_LOG_MAX) : dec_log; // clamp
    assign dec_last = 5'((32'd1 << dec_sel) - 1);
    assign dump     = (dec_cnt_reg == dec_last);

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            dec_cnt_reg <= '0;
            acc_i_reg   <= '0;
            acc_q_reg   <= '0;
        end else if (restart_evt || dump) begin
            dec_cnt_reg <= '0;
            acc_i_reg   <= restart_evt ? 26'sh0 : 26'(mix_i);
            acc_q_reg   <= restart_evt ? 26'sh0 : 26'(mix_q);
        end else begin
            dec_cnt_reg <= dec_cnt_reg + 5'h01;
            acc_i_reg   <= acc_i_reg + 26'(mix_i);
            acc_q_reg   <= acc_q_reg + 26'(mix_q);
        end
    end

    assign avg_i = 20'(acc_i_reg >>> dec_sel);
    assign avg_q = 20'(acc_q_reg >>> dec_sel);

    // ****************************************************************
    // gain with saturation
    // ****************************************************************
    function automatic logic signed [19:0] sat20(input logic signed [22:0] v);
        if (v > 23'sh07ffff) begin
            return 20'sh7ffff;
        end else if (v < -23'sh080000) begin
            return -20'sh80000;
        end
        return v[19:0];
    endfunction : sat20

    function automatic logic signed [19:0] gain(input logic signed [19:0] v, input logic real_m);
        logic signed [22:0] w;
        w = 23'(v);
        if (real_m) begin
            w = w + (w >>> `DDC_SQRT2_SH1) + (w >>> `DDC_SQRT2_SH2)
                  + (w >>> `DDC_SQRT2_SH3) + (w >>> `DDC_SQRT2_SH4);
        end else begin
            w = w <<< 1;
        end
        return sat20(w);
    endfunction : gain

    logic signed [19:0] g_i, g_q;
    assign g_i = gain_en ? gain(avg_i, mode == DDC_MODE_REAL) : avg_i;
    assign g_q = gain_en ? gain(avg_q, mode == DDC_MODE_REAL) : avg_q;

    // ****************************************************************
    // quarter-rate mix and output formatter
    // ****************************************************************
    logic [1:0]         qrot_reg;
    logic signed [19:0] word_a, word_b;
    logic [19:0]        mask;
    logic               push, push_b, out_ready, pend_reg;
    logic [19:0]        pend_data_reg;
    logic [20:0]        fifo_in, fifo_out;

    // rotate by j^n: i, -q, -i, q gives real samples at twice the rate
    always_comb begin
        word_a = g_i;
        word_b = g_q;
        if (mode == DDC_MODE_QUARTER) begin
            unique case (qrot_reg)
                2'h0: begin word_a = g_i;  word_b = -g_q; end
                2'h1: begin word_a = -g_q; word_b = -g_i; end
                2'h2: begin word_a = -g_i; word_b = g_q;  end
                default: begin word_a = g_q; word_b = g_i; end
            endcase
        end
    end

    // keep top bits only, lower ones truncated
    assign mask = ~((20'h1 << (5'd20 - out_res)) - 20'h1);

    // bypass passes each raw sample; otherwise decimated words
    assign push   = ddc_enable ? (dump && !restart_evt) : 1'b1;
    assign push_b = ddc_enable && (mode != DDC_MODE_REAL);

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            qrot_reg      <= '0;
            pend_reg      <= 1'b0;
            pend_data_reg <= '0;
        end else begin
            if (push && ddc_enable) begin
                qrot_reg <= qrot_reg + 2'h2;
            end
            if (push && push_b && out_ready && !pend_reg) begin
                pend_reg      <= 1'b1;
                pend_data_reg <= word_b & mask;
            end else if (pend_reg && out_ready) begin
                pend_reg <= 1'b0;
            end
        end
    end

    // second word of a pair goes the cycle after the first
    always_comb begin
        if (pend_reg) begin
            fifo_in = {(mode != DDC_MODE_QUARTER), pend_data_reg};
        end else if (ddc_enable) begin
            fifo_in = {1'b0, word_a & mask};
        end else begin
            fifo_in = {1'b0, {sel_sample, 4'h0} & mask};
        end
    end

    ddc_fifo #(
        .WIDTH (21),
        .DEPTH (`DDC_FIFO_DEPTH)
    ) u_fifo (
        .mclk      (mclk),
        .rst       (rst),
        .in_valid  (pend_reg || (push && !pend_reg)),
        .in_ready  (out_ready),
        .in_data   (fifo_in),
        .out_valid (link.valid),
        .out_ready (link.ready),
        .out_data  (fifo_out)
    );

    assign link.data = fifo_out[19:0];
    assign link.is_q = fifo_out[20];
endmodule : ddc_dev

// file: rtl/ddc_host.sv
`timescale 1ns/1ps
`include "ddc_cfg.svh"
// ****************************************************************
// host end: configures the converter, drains its words
// ****************************************************************
module ddc_host
    import ddc_pkg::*;
(
    input  wire logic                  mclk,
    input  wire logic                  rst,
    input  wire logic                  cfg_load,
    input  wire logic [31:0]           cfg_word,
    input  wire ddc_pkg::ddc_mode_t    cfg_mode,
    input  wire logic                  accept,
    output logic [31:0]                nco_word,
    output logic                       mixer_restart,
    output logic                       reference_select_pin,
    output logic                       ref_amp_power_down,
    output logic                       got_valid,
    output logic [19:0]                got_data,
    output logic                       got_is_q,
    ddc_link_if.host                   link
);
    import ddc_pkg::*;

    // word write then restart toggle next cycle
    logic load_d_reg;
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            nco_word      <= '0;
            mixer_restart <= 1'b0;
            load_d_reg    <= 1'b0;
        end else begin
            load_d_reg <= cfg_load;
            if (cfg_load) begin
                nco_word <= (cfg_mode == DDC_MODE_REAL) ? 32'h0 : cfg_word;
            end
            if (load_d_reg) begin
                mixer_restart <= ~mixer_restart;
            end
        end
    end

    // pin tied high, amplifier kept running
    assign reference_select_pin = 1'b1;
    assign ref_amp_power_down   = 1'b0;

    // accept words when told to; back-pressure otherwise
    assign link.ready = accept;
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            got_valid <= 1'b0;
            got_data  <= '0;
            got_is_q  <= 1'b0;
        end else begin
            got_valid <= link.valid && accept;
            if (link.valid && accept) begin
                got_data <= link.data;
                got_is_q <= link.is_q;
            end
        end
    end
endmodule : ddc_host

// file: dv/ddc_link_asserts.sv
`timescale 1ns/1ps
// ****************************************
// link checks between converter and host
// ****************************************
module ddc_link_asserts (
    input wire logic               mclk,
    input wire logic               rst,
    input wire logic               valid,
    input wire logic               ready,
    input wire logic [19:0]        data,
    input wire logic               is_q,
    input wire logic               ddc_enable,
    input wire ddc_pkg::ddc_mode_t mode,
    input wire logic [4:0]         out_res
);
    import ddc_pkg::*;
    logic [7:0]  settle_reg;
    logic        i_open_reg;
    logic [19:0] low_mask;
    logic        settled;
    logic [7:0]  setup_d_reg;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    // cycles of steady setup with the host draining; old words are gone by 255
    always_ff @(posedge mclk or posedge rst) begin
        if (rst)
            settle_reg <= 8'h00;
        else if (!ready || !$stable(mode) || !$stable(ddc_enable) || !$stable(out_res))
            settle_reg <= 8'h00;
        else if (settle_reg != 8'hff)
            settle_reg <= settle_reg + 8'h01;
    end

    // setup seen at the previous edge; a change voids settled at once
    always_ff @(posedge mclk or posedge rst) begin
        if (rst)
            setup_d_reg <= 8'h00;
        else
            setup_d_reg <= {ddc_enable, mode, out_res};
    end

    // an in-phase word was taken and its partner is still owed
    always_ff @(posedge mclk or posedge rst) begin
        if (rst)
            i_open_reg <= 1'b0;
        else if (valid && ready)
            i_open_reg <= !is_q;
    end

    // bits below the chosen resolution
    assign low_mask = 20'hfffff >> out_res;
    assign settled  = (settle_reg == 8'hff) && (setup_d_reg == {ddc_enable, mode, out_res});

    a_valid_holds: assert property (valid && !ready |=> valid)
        else $error("valid dropped before ready");
    a_word_holds: assert property (valid && !ready |=> $stable(data) && $stable(is_q))
        else $error("word changed while stalled");
    a_reset_idle: assert property ($fell(rst) |-> !valid)
        else $error("valid high right after reset");
    a_q_after_i: assert property (valid && ready && is_q |-> i_open_reg)
        else $error("quadrature word without in-phase word");
    a_pair_next: assert property (settled && ddc_enable && mode == DDC_MODE_COMPLEX && valid && ready && !is_q
        |=> valid && is_q)
        else $error("quadrature word not next to in-phase word");
    a_real_no_q: assert property (settled && ddc_enable && mode == DDC_MODE_REAL && valid |-> !is_q)
        else $error("quadrature word in real mode");
    a_quarter_real: assert property (settled && ddc_enable && mode == DDC_MODE_QUARTER && valid |-> !is_q)
        else $error("quadrature word in quarter mode");
    a_bypass_no_q: assert property (settled && !ddc_enable && valid |-> !is_q)
        else $error("quadrature word in bypass");
    a_trunc_bits: assert property (settled && valid |-> (data & low_mask) == 20'h00000)
        else $error("bits below resolution not cleared");

    c_pair: cover property (valid && ready && !is_q ##1 valid && ready && is_q);
    c_stall: cover property (valid && !ready [*4]);
    c_real: cover property (settled && mode == DDC_MODE_REAL && valid && ready);
endmodule : ddc_link_asserts

// file: dv/tb_ddc_decimation_nco.sv
`timescale 1ns/1ps
`include "ddc_cfg.svh"
// ****************************************
// bench: both ends joined by the link
// ****************************************
module tb_ddc_decimation_nco;
    import ddc_pkg::*;
    logic               mclk = 1'b0;
    logic               rst = 1'b1;
    logic signed [15:0] conv_ch_one = 16'sh0000;
    logic signed [15:0] conv_ch_two = 16'sh0000;
    logic               ddc_enable = 1'b0;
    ddc_mode_t          mode = DDC_MODE_COMPLEX;
    logic [2:0]         dec_log = 3'h1;
    logic               path_swap = 1'b0;
    logic               gain_en = 1'b0;
    logic               phase_invert = 1'b0;
    logic               sync_pin = 1'b0;
    logic [4:0]         out_res = 5'h10;
    logic               use_path_two = 1'b0;
    ddc_refsel_t        ref_source = DDC_REF_PIN;
    logic               ref_soft_mode = 1'b0;
    logic               cfg_load = 1'b0;
    logic [31:0]        cfg_word = 32'h0;
    logic               accept = 1'b1;
    logic               ref_mode, mixer_restart, reference_select_pin, ref_amp_power_down;
    logic               got_valid, got_is_q, old_rs;
    logic [31:0]        nco_word;
    logic [19:0]        got_data, d;
    int                 fails = 0;
    int                 check_count = 0;
    int                 n, i;

    ddc_link_if link ();
    ddc_dev u_ddc_dev (.mclk(mclk), .rst(rst), .conv_ch_one(conv_ch_one), .conv_ch_two(conv_ch_two),
        .ddc_enable(ddc_enable), .mode(mode), .dec_log(dec_log), .path_swap(path_swap), .gain_en(gain_en),
        .phase_invert(phase_invert), .nco_word(nco_word), .mixer_restart(mixer_restart), .sync_pin(sync_pin),
        .out_res(out_res), .use_path_two(use_path_two), .reference_select_pin(reference_select_pin),
        .ref_source(ref_source), .ref_soft_mode(ref_soft_mode), .ref_mode(ref_mode), .link(link.dev));
    ddc_host u_ddc_host (.mclk(mclk), .rst(rst), .cfg_load(cfg_load), .cfg_word(cfg_word), .cfg_mode(mode),
        .accept(accept), .nco_word(nco_word), .mixer_restart(mixer_restart),
        .reference_select_pin(reference_select_pin), .ref_amp_power_down(ref_amp_power_down),
        .got_valid(got_valid), .got_data(got_data), .got_is_q(got_is_q), .link(link.host));
    ddc_link_asserts u_ddc_link_asserts (.mclk(mclk), .rst(rst), .valid(link.valid), .ready(link.ready),
        .data(link.data), .is_q(link.is_q), .ddc_enable(ddc_enable), .mode(mode), .out_res(out_res));

    // clock at 250 MHz
    always #2 mclk = ~mclk;

    // compare and count
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            fails++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic cyc(input int k);
        repeat (k) @(negedge mclk);
    endtask : cyc

    // new setup, then let the pipeline and fifo settle
    task automatic setup(input logic en, input ddc_mode_t m, input logic [2:0] dl);
        @(negedge mclk);
        ddc_enable = en;
        mode = m;
        dec_log = dl;
        cyc(300);
    endtask : setup

    // next word handed to the host, bounded wait
    task automatic get_word(output logic [19:0] w);
        int k;
        k = 0;
        @(negedge mclk);
        while (got_valid !== 1'b1 && k < 400) begin
            @(negedge mclk);
            k++;
        end
        w = got_data;
        if (k >= 400) check("word wait", 32'h0, 32'h1);
    endtask : get_word

    task automatic count_words(input int span, output int c);
        c = 0;
        repeat (span) begin
            @(negedge mclk);
            if (got_valid === 1'b1 && got_is_q === 1'b0) c++;
        end
    endtask : count_words

    // host loads a frequency word
    task automatic load_word(input logic [31:0] w);
        @(negedge mclk);
        old_rs = mixer_restart;
        cfg_word = w;
        cfg_load = 1'b1;
        @(negedge mclk);
        cfg_load = 1'b0;
        cyc(4);
    endtask : load_word

    task automatic t_bypass;
        conv_ch_one = 16'sh2468;
        setup(1'b0, DDC_MODE_COMPLEX, 3'h1);
        get_word(d);
        check("bypass word", {12'h0, d}, 32'h24680);
        check("bypass q", {31'h0, got_is_q}, 32'h0);
        $display("done bypass");
    endtask : t_bypass

    task automatic t_host;
        setup(1'b1, DDC_MODE_COMPLEX, 3'h2);
        load_word(32'h2762_7627);
        check("freq word", nco_word, 32'h2762_7627);
        check("restart toggled", {31'h0, mixer_restart ^ old_rs}, 32'h1);
        sync_pin = ~sync_pin;
        count_words(256, n);
        check("rate after sync", n, 32'd64);
        mode = DDC_MODE_REAL;
        load_word(32'h1234_5678);
        check("real freq zero", nco_word, 32'h0);
        check("ref pin high", {31'h0, reference_select_pin}, 32'h1);
        check("ref amp on", {31'h0, ref_amp_power_down}, 32'h0);
        check("ref from pin", {31'h0, ref_mode}, 32'h1);
        ref_source = DDC_REF_SOFT;
        for (i = 0; i < 2; i++) begin
            ref_soft_mode = i[0];
            cyc(4);
            check("ref from soft", {31'h0, ref_mode}, {31'h0, i[0]});
        end
        $display("done host");
    endtask : t_host

    task automatic t_real;
        conv_ch_one = 16'sh1000;
        setup(1'b1, DDC_MODE_REAL, 3'h2);
        get_word(d);
        check("real word", {12'h0, d}, 32'h10000);
        gain_en = 1'b1;
        cyc(300);
        get_word(d);
        check("real gain", {12'h0, d}, 32'h10000 + (32'h10000 >> `DDC_SQRT2_SH1) + (32'h10000 >> `DDC_SQRT2_SH2)
            + (32'h10000 >> `DDC_SQRT2_SH3) + (32'h10000 >> `DDC_SQRT2_SH4));
        conv_ch_one = 16'sh7fff;
        cyc(300);
        get_word(d);
        check("gain saturates", {12'h0, d}, 32'h7fff0);
        gain_en = 1'b0;
        conv_ch_one = 16'sh1237;
        out_res = 5'h0e;
        cyc(300);
        get_word(d);
        check("res 14", {12'h0, d}, 32'h12340);
        out_res = 5'h14;
        cyc(300);
        get_word(d);
        check("res 20", {12'h0, d}, 32'h12370);
        out_res = 5'h10;
        $display("done real");
    endtask : t_real

    task automatic t_swap;
        logic [1:0]  sel [4] = '{2'b00, 2'b01, 2'b10, 2'b11};
        logic [19:0] exp [4] = '{20'h10000, 20'h08000, 20'h08000, 20'h10000};
        conv_ch_one = 16'sh1000;
        conv_ch_two = 16'sh0800;
        for (i = 0; i < 4; i++) begin
            {use_path_two, path_swap} = sel[i];
            cyc(300);
            get_word(d);
            check("crossbar", {12'h0, d}, {12'h0, exp[i]});
        end
        {use_path_two, path_swap} = 2'b00;
        $display("done swap");
    endtask : t_swap

    task automatic t_rate;
        ddc_mode_t  md [7] = '{DDC_MODE_COMPLEX, DDC_MODE_COMPLEX, DDC_MODE_COMPLEX, DDC_MODE_COMPLEX,
                               DDC_MODE_COMPLEX, DDC_MODE_QUARTER, DDC_MODE_REAL};
        logic [2:0] dl [7] = '{3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h3, 3'h3};
        int         ex [7] = '{128, 64, 32, 16, 8, 64, 32};
        gain_en = 1'b1;
        for (i = 0; i < 7; i++) begin
            setup(1'b1, md[i], dl[i]);
            count_words(256, n);
            check("word rate", {31'h0, n >= ex[i] - 1 && n <= ex[i] + 1}, 32'h1);
        end
        gain_en = 1'b0;
        $display("done rate");
    endtask : t_rate

    // host stalls until the fifo refuses, then drains it
    task automatic t_fill;
        setup(1'b1, DDC_MODE_REAL, 3'h5);
        accept = 1'b0;
        cyc(700);
        accept = 1'b1;
        count_words(24, n);
        check("fifo drain", {31'h0, n >= `DDC_FIFO_DEPTH && n <= `DDC_FIFO_DEPTH + 1}, 32'h1);
        $display("done fill");
    endtask : t_fill

    // first pair after a restart: inversion negates q, 6 dB gain doubles i
    task automatic t_cplx;
        logic [19:0] w [6];
        conv_ch_one = 16'sh0800;
        setup(1'b1, DDC_MODE_COMPLEX, 3'h2);
        for (i = 0; i < 3; i++) begin
            phase_invert = (i == 1);
            gain_en = (i == 2);
            load_word(32'h1000_0000);
            cyc(3);
            w[2*i] = got_data;
            cyc(1);
            w[2*i+1] = got_data;
            check("q flag", {31'h0, got_is_q}, 32'h1);
        end
        check("q positive", {31'h0, w[1][19] || w[1] == 20'h0}, 32'h0);
        check("invert i", {12'h0, w[2]}, {12'h0, w[0]});
        check("invert q", {12'h0, w[3]}, {12'h0, -w[1]});
        check("gain i", {12'h0, w[4]}, {12'h0, w[0] << 1});
        phase_invert = 1'b0;
        gain_en = 1'b0;
        $display("done cplx");
    endtask : t_cplx

    task automatic finish_test;
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : finish_test

    // main sequence
    initial begin
        cyc(4);
        rst = 1'b0;
        cyc(2);
        t_bypass();
        t_host();
        t_real();
        t_swap();
        t_rate();
        t_fill();
        t_cplx();
        finish_test();
    end

    // watchdog
    initial begin
        repeat (60000) @(posedge mclk);
        fails++;
        finish_test();
    end
endmodule : tb_ddc_decimation_nco
